// ### include/ttw_map.svh
`ifndef TTW_MAP_SVH
`define TTW_MAP_SVH

// ************************************************************
// Register byte offsets.
// ************************************************************
`define TTW_OFF_PWR     8'h00
`define TTW_OFF_PRESC   8'h04
`define TTW_OFF_NF      8'h08
`define TTW_OFF_MODE    8'h0c
`define TTW_OFF_TRIG    8'h10
`define TTW_OFF_STAT    8'h14
`define TTW_OFF_COUNT   8'h18
`define TTW_OFF_DATA    8'h1c
`define TTW_OFF_OUT     8'h20

// ************************************************************
// Field positions.
// ************************************************************
`define TTW_PWR_EN      0
`define TTW_NF_EN       0
`define TTW_MODE_MD_HI  3
`define TTW_MODE_MD_LO  1
`define TTW_MODE_CIS_HI 7
`define TTW_MODE_CIS_LO 6
`define TTW_MODE_STS_HI 10
`define TTW_MODE_STS_LO 8
`define TTW_MODE_SPLIT  11
`define TTW_MODE_CKS_HI 15
`define TTW_MODE_CKS_LO 14
`define TTW_TRIG_START  0
`define TTW_TRIG_STOP   1
`define TTW_TRIG_USTART 2
`define TTW_TRIG_USTOP  3
`define TTW_STAT_EN     0
`define TTW_STAT_UEN    1
`define TTW_STAT_OVF    2
`define TTW_OUT_OE      0
`define TTW_OUT_VAL     1
`define TTW_OUT_MODE    2
`define TTW_OUT_LVL     3

// ************************************************************
// Reset values and counts.
// ************************************************************
`define TTW_RST_WORD16  16'h0000
`define TTW_CNT_ZERO    16'h0000
`define TTW_CNT_FULL    16'hffff
`define TTW_CNT_ONE     16'h0001

`endif

// ### include/ttw_pkg.sv
package ttw_pkg;

    typedef enum logic [1:0] {
        TTW_ST_IDLE = 2'b00,
        TTW_ST_WAIT = 2'b01,
        TTW_ST_RUN  = 2'b11
    } ttw_state_t;

    typedef enum logic [2:0] {
        TTW_MD_ONE_COUNT = 3'b100,
        TTW_MD_CAPT_ONE  = 3'b110
    } ttw_mode_t;

    typedef enum logic [1:0] {
        TTW_EDGE_FALL   = 2'b00,
        TTW_EDGE_RISE   = 2'b01,
        TTW_EDGE_LOW_W  = 2'b10,
        TTW_EDGE_HIGH_W = 2'b11
    } ttw_edge_t;

    typedef enum logic [2:0] {
        TTW_STS_SOFT = 3'b000,
        TTW_STS_PIN  = 3'b010
    } ttw_start_t;

endpackage

// ### hw/ttw_prescaler.sv
`timescale 1ns/1ns
// ************************************************************
// Free-running divider giving four prescaled tick pulses.
// ************************************************************
module ttw_prescaler #(
    parameter int CNT_W = 16
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              run_i,
    input  wire logic [15:0]       sel_i,
    output logic      [3:0]        tick_o
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [3:0]       tick_next;

    function automatic logic [CNT_W-1:0] div_mask(input logic [3:0] sel);
        div_mask = CNT_W'((32'h1 << sel) - 32'h1);
    endfunction

    assign cnt_next = run_i ? cnt_reg + CNT_W'(1) : '0;

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_tick
            assign tick_next[k] = run_i &&
                ((cnt_reg & div_mask(sel_i[4*k+3:4*k])) == div_mask(sel_i[4*k+3:4*k]));
        end
    endgenerate

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            tick_o  <= 4'h0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o  <= tick_next;
        end
    end

endmodule

// ### hw/ttw_in_cond.sv
`timescale 1ns/1ns
// ************************************************************
// Pin synchroniser, tick-sampled noise filter and edge detect.
// ************************************************************
module ttw_in_cond (
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    input  wire logic run_i,
    input  wire logic pin_i,
    input  wire logic tick_i,
    input  wire logic filt_en_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic sync1_reg;
    logic sync2_reg;
    logic samp_reg;
    logic level_next;
    logic take;

    // Filter on: a level must be seen on two successive ticks.
    assign take       = tick_i && (!filt_en_i || (samp_reg == sync2_reg));
    assign level_next = take ? sync2_reg : level_o;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !run_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            samp_reg  <= 1'b0;
            level_o   <= 1'b0;
            rise_o    <= 1'b0;
            fall_o    <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            if (tick_i) begin
                samp_reg <= sync2_reg;
            end
            level_o   <= level_next;
            rise_o    <= level_next && !level_o;
            fall_o    <= !level_next && level_o;
        end
    end

endmodule

// ### hw/ttw_timer.sv
`timescale 1ns/1ns
`include "ttw_map.svh"

module ttw_timer #(
    parameter int CHANNEL = 1
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timer_input_pin_i,
    output logic             channel_interrupt_o,
    output logic             timer_output_o
);

    // ************************************************************
    // Registers and decode.
    // ************************************************************
    localparam bit HAS_UPPER = (CHANNEL == 1) || (CHANNEL == 3);

    logic                   pwr_reg;
    logic [15:0]            presc_reg;
    logic                   nf_reg;
    logic [15:0]            mode_reg;
    logic [3:0]             out_reg;
    logic [15:0]            data_reg;
    logic [15:0]            count_reg;
    logic [15:0]            count_next;
    logic                   en_reg;
    logic                   uen_reg;
    logic                   ovf_reg;
    logic                   wrap_reg;
    logic                   irq_reg;
    ttw_pkg::ttw_state_t    state_reg;
    ttw_pkg::ttw_state_t    state_next;

    logic [3:0]  ticks;
    logic        tick;
    logic        pin_level;
    logic        pin_rise;
    logic        pin_fall;
    logic        wr_acc;
    logic        rd_setup;
    logic        wr_ok;
    logic        mapped;
    logic        is_width;
    logic        is_delay;
    logic        frozen;
    logic        sw_start;
    logic        sw_stop;
    logic        up_start;
    logic        up_stop;
    logic        start_edge;
    logic        capt_edge;
    logic        valid_edge;
    logic        pin_trig;
    logic        capture;
    logic        dly_load;
    logic        dly_zero;
    logic [1:0]  cks_eff;
    logic [15:0] mode_wmask;
    logic [31:0] rd_mux;

    function automatic logic sel_hit(input logic [7:0] a, input logic [7:0] off);
        sel_hit = (a == off);
    endfunction

    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_ok    = wr_acc && pwr_reg;
    assign mapped   = sel_hit(paddr, `TTW_OFF_PWR)   || sel_hit(paddr, `TTW_OFF_PRESC) ||
                      sel_hit(paddr, `TTW_OFF_NF)    || sel_hit(paddr, `TTW_OFF_MODE)  ||
                      sel_hit(paddr, `TTW_OFF_TRIG)  || sel_hit(paddr, `TTW_OFF_STAT)  ||
                      sel_hit(paddr, `TTW_OFF_COUNT) || sel_hit(paddr, `TTW_OFF_DATA)  ||
                      sel_hit(paddr, `TTW_OFF_OUT);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    assign is_width = mode_reg[`TTW_MODE_MD_HI:`TTW_MODE_MD_LO] == ttw_pkg::TTW_MD_CAPT_ONE;
    assign is_delay = mode_reg[`TTW_MODE_MD_HI:`TTW_MODE_MD_LO] == ttw_pkg::TTW_MD_ONE_COUNT;
    assign frozen   = pwr_reg && en_reg && is_width;

    assign sw_start = wr_ok && sel_hit(paddr, `TTW_OFF_TRIG) && pwdata[`TTW_TRIG_START];
    assign sw_stop  = wr_ok && sel_hit(paddr, `TTW_OFF_TRIG) && pwdata[`TTW_TRIG_STOP];
    assign up_start = HAS_UPPER && wr_ok && sel_hit(paddr, `TTW_OFF_TRIG)
                      && pwdata[`TTW_TRIG_USTART];
    assign up_stop  = HAS_UPPER && wr_ok && sel_hit(paddr, `TTW_OFF_TRIG)
                      && pwdata[`TTW_TRIG_USTOP];

    // Split bit and the upper clock codes exist only on channels 1 and 3.
    assign mode_wmask = HAS_UPPER ? 16'hffff : 16'h87ff;
    assign cks_eff    = mode_reg[`TTW_MODE_CKS_HI:`TTW_MODE_CKS_LO];
    assign tick       = pwr_reg && ((cks_eff == 2'b00) ? ticks[0] :
                                    (cks_eff == 2'b10) ? ticks[1] :
                                    (cks_eff == 2'b01) ? ticks[2] : ticks[3]);

    // ************************************************************
    // Clock divider and input conditioning.
    // ************************************************************
    ttw_prescaler #(
        .CNT_W (16)
    ) u_presc (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (pwr_reg),
        .sel_i     (presc_reg),
        .tick_o    (ticks)
    );

    ttw_in_cond u_in (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .run_i     (pwr_reg),
        .pin_i     (timer_input_pin_i),
        .tick_i    (tick),
        .filt_en_i (nf_reg),
        .level_o   (pin_level),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    // ************************************************************
    // Edge roles.
    // ************************************************************
    assign start_edge = pwr_reg && ((mode_reg[`TTW_MODE_CIS_HI:`TTW_MODE_CIS_LO] ==
                        ttw_pkg::TTW_EDGE_HIGH_W) ? pin_rise : pin_fall);
    assign capt_edge  = (mode_reg[`TTW_MODE_CIS_HI:`TTW_MODE_CIS_LO] == ttw_pkg::TTW_EDGE_HIGH_W)
                        ? pin_fall : pin_rise;
    assign valid_edge = mode_reg[`TTW_MODE_CIS_HI] ? (pin_rise || pin_fall) :
                        mode_reg[`TTW_MODE_CIS_LO] ? pin_rise : pin_fall;
    assign pin_trig   = mode_reg[`TTW_MODE_STS_HI:`TTW_MODE_STS_LO] == ttw_pkg::TTW_STS_PIN;

    assign capture  = pwr_reg && is_width && (state_reg == ttw_pkg::TTW_ST_RUN) && capt_edge;
    assign dly_load = pwr_reg && is_delay && en_reg && !sw_stop &&
                      ((pin_trig && valid_edge) || sw_start);
    assign dly_zero = is_delay && (state_reg == ttw_pkg::TTW_ST_RUN) && tick &&
                      (count_reg == `TTW_CNT_ZERO);

    // ************************************************************
    // Channel state machine.
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        unique case (state_reg)
            ttw_pkg::TTW_ST_IDLE: begin
                if (sw_start || up_start) begin
                    state_next = ttw_pkg::TTW_ST_WAIT;
                end
            end
            ttw_pkg::TTW_ST_WAIT: begin
                if (is_width && start_edge) begin
                    state_next = ttw_pkg::TTW_ST_RUN;
                    count_next = `TTW_CNT_ZERO;
                end else if (dly_load) begin
                    state_next = ttw_pkg::TTW_ST_RUN;
                    count_next = data_reg;
                end
            end
            ttw_pkg::TTW_ST_RUN: begin
                if (capture) begin
                    state_next = ttw_pkg::TTW_ST_WAIT;
                    count_next = count_reg + `TTW_CNT_ONE;
                end else if (dly_load) begin
                    count_next = data_reg;
                end else if (dly_zero) begin
                    state_next = ttw_pkg::TTW_ST_WAIT;
                end else if (tick) begin
                    count_next = is_width ? count_reg + `TTW_CNT_ONE
                                          : count_reg - `TTW_CNT_ONE;
                end
            end
            default: begin
                state_next = ttw_pkg::TTW_ST_IDLE;
            end
        endcase
        if (sw_stop) begin
            state_next = ttw_pkg::TTW_ST_IDLE;
            count_next = count_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !pwr_reg) begin
            state_reg <= ttw_pkg::TTW_ST_IDLE;
            count_reg <= `TTW_RST_WORD16;
            en_reg    <= 1'b0;
            uen_reg   <= 1'b0;
            ovf_reg   <= 1'b0;
            wrap_reg  <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            irq_reg   <= capture || dly_zero;
            if (sw_stop) begin
                en_reg <= 1'b0;
            end else if (sw_start) begin
                en_reg <= 1'b1;
            end
            if (up_stop) begin
                uen_reg <= 1'b0;
            end else if (up_start) begin
                uen_reg <= 1'b1;
            end
            if (capture) begin
                ovf_reg  <= wrap_reg || (count_reg == `TTW_CNT_FULL);
                wrap_reg <= 1'b0;
            end else if (state_reg == ttw_pkg::TTW_ST_WAIT && state_next == ttw_pkg::TTW_ST_RUN) begin
                wrap_reg <= 1'b0;
            end else if (is_width && state_reg == ttw_pkg::TTW_ST_RUN && tick &&
                         count_reg == `TTW_CNT_FULL) begin
                wrap_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Software registers.
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pwr_reg <= 1'b0;
        end else if (wr_acc && sel_hit(paddr, `TTW_OFF_PWR)) begin
            pwr_reg <= pwdata[`TTW_PWR_EN];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !pwr_reg) begin
            presc_reg <= `TTW_RST_WORD16;
            nf_reg    <= 1'b0;
            mode_reg  <= `TTW_RST_WORD16;
            out_reg   <= 4'h0;
            data_reg  <= `TTW_RST_WORD16;
        end else begin
            if (wr_ok && sel_hit(paddr, `TTW_OFF_PRESC)) begin
                presc_reg <= pwdata[15:0];
            end
            if (wr_ok && sel_hit(paddr, `TTW_OFF_NF)) begin
                nf_reg <= pwdata[`TTW_NF_EN];
            end
            if (wr_ok && sel_hit(paddr, `TTW_OFF_MODE) && !frozen) begin
                mode_reg <= pwdata[15:0] & mode_wmask;
            end
            if (wr_ok && sel_hit(paddr, `TTW_OFF_OUT) && !frozen) begin
                out_reg <= pwdata[3:0];
            end
            if (capture) begin
                data_reg <= count_reg;
            end else if (wr_ok && sel_hit(paddr, `TTW_OFF_DATA)) begin
                data_reg <= pwdata[15:0];
            end
        end
    end

    assign rd_mux = sel_hit(paddr, `TTW_OFF_PWR)   ? {31'h0, pwr_reg} :
                    sel_hit(paddr, `TTW_OFF_PRESC) ? {16'h0, presc_reg} :
                    sel_hit(paddr, `TTW_OFF_NF)    ? {31'h0, nf_reg} :
                    sel_hit(paddr, `TTW_OFF_MODE)  ? {16'h0, mode_reg} :
                    sel_hit(paddr, `TTW_OFF_STAT)  ? {29'h0, ovf_reg, uen_reg, en_reg} :
                    sel_hit(paddr, `TTW_OFF_COUNT) ? {16'h0, count_reg} :
                    sel_hit(paddr, `TTW_OFF_DATA)  ? {16'h0, data_reg} :
                    sel_hit(paddr, `TTW_OFF_OUT)   ? {28'h0, out_reg} :
                    32'h0;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            prdata <= 32'h0;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    assign channel_interrupt_o = irq_reg;
    assign timer_output_o      = out_reg[`TTW_OUT_VAL];

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    power_off_idle_a: assert property (!pwr_reg |=> (state_reg == ttw_pkg::TTW_ST_IDLE && !en_reg))
        else $error("Channel not idle while powered off.");
    write_block_a: assert property (!pwr_reg && wr_acc && sel_hit(paddr, `TTW_OFF_DATA)
                                    |=> data_reg == `TTW_RST_WORD16)
        else $error("Data register written while powered off.");
    start_sets_en_a: assert property (sw_start && !sw_stop |=> en_reg && state_reg != ttw_pkg::TTW_ST_IDLE)
        else $error("Start trigger did not enable the channel.");
    start_clear_a: assert property (is_width && state_reg == ttw_pkg::TTW_ST_WAIT && start_edge && !sw_stop
                                    |=> count_reg == `TTW_CNT_ZERO && state_reg == ttw_pkg::TTW_ST_RUN)
        else $error("Start edge did not clear the counter.");
    capture_data_a: assert property (capture && !sw_stop
                                     |=> data_reg == $past(count_reg) && channel_interrupt_o)
        else $error("Capture did not copy counter with interrupt.");
    capture_ovf_a: assert property (capture && !sw_stop |=> ovf_reg == ($past(wrap_reg) ||
                                    $past(count_reg) == `TTW_CNT_FULL))
        else $error("Overflow flag wrong after capture.");
    capture_stop_a: assert property (capture && !sw_stop |=> ##1 $stable(count_reg)[*2])
        else $error("Counter kept running after capture.");
    stop_hold_a: assert property (sw_stop && pwr_reg
                                  |=> !en_reg && $stable(count_reg) && $stable(ovf_reg))
        else $error("Stop did not hold counter and flag.");
    delay_load_a: assert property (dly_load && state_reg != ttw_pkg::TTW_ST_IDLE
                                   |=> count_reg == $past(data_reg))
        else $error("Delay start did not load data register.");
    zero_irq_a: assert property (dly_zero && !sw_stop && !dly_load
                                 |=> channel_interrupt_o && state_reg == ttw_pkg::TTW_ST_WAIT)
        else $error("Zero count gave no interrupt.");
    zero_hold_a: assert property (is_delay && state_reg == ttw_pkg::TTW_ST_WAIT && !dly_load
                                  && count_reg == `TTW_CNT_ZERO |=> count_reg == `TTW_CNT_ZERO)
        else $error("Counter left zero without an edge.");
    trig_reads_zero_a: assert property (rd_setup && sel_hit(paddr, `TTW_OFF_TRIG) |=> prdata == 32'h0)
        else $error("Trigger register did not read zero.");
    mode_frozen_a: assert property (frozen && !sw_stop |=> $stable(mode_reg) && $stable(out_reg))
        else $error("Mode changed during width measurement.");
    down_step_a: assert property (is_delay && state_reg == ttw_pkg::TTW_ST_RUN && tick && !dly_load
                                  && !sw_stop && count_reg != `TTW_CNT_ZERO
                                  |=> count_reg == $past(count_reg) - `TTW_CNT_ONE)
        else $error("Down counter step wrong.");

    width_cycle_c: cover property (capture ##[1:50] capture);
    delay_irq_c:   cover property (dly_load ##[1:50] dly_zero);
    soft_delay_c:  cover property (is_delay && sw_start && en_reg);
    overflow_c:    cover property (capture && wrap_reg);

endmodule

// ### tb/ttw_pulse_src.sv
`timescale 1ns/1ns
// ************************************************************
// Pulse source that drives the timer input pin.
// ************************************************************
module ttw_pulse_src (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [15:0] width_i,
    output logic             pin_o
);
    logic [15:0] left_reg = 16'h0000;
    always @(posedge clk_i) begin
        if (go_i) begin
            left_reg <= width_i;
        end else if (left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end
    assign pin_o = (left_reg != 16'h0000);
endmodule

// ### tb/timer_width_measure_delay_count_bench.sv
`timescale 1ns/1ns
`include "ttw_map.svh"
// ************************************************************
// Register accesses, pin pulses and checks.
// ************************************************************
module timer_width_measure_delay_count_bench;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [7:0]  paddr     = 8'h00;
    logic [31:0] pwdata    = 32'h00000000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, pin, irq, er, tout;
    logic        go        = 1'b0;
    logic [15:0] wid       = 16'h0000;
    int          n_fail    = 0;
    int          n_tests   = 0;
    int          cyc;
    always #25 ref_clk_i = ~ref_clk_i;
    ttw_pulse_src src (.clk_i(ref_clk_i), .go_i(go), .width_i(wid), .pin_o(pin));
    ttw_timer dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_input_pin_i(pin), .channel_interrupt_o(irq),
        .timer_output_o(tout));
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        @(posedge ref_clk_i);
        while (pready !== 1'b1) @(posedge ref_clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask
    task pulse(input logic [15:0] w);
        @(posedge ref_clk_i);
        go <= 1'b1;
        wid <= w;
        @(posedge ref_clk_i);
        go <= 1'b0;
    endtask
    task wait_irq;
        cyc = 0;
        do begin
            @(posedge ref_clk_i);
            cyc++;
        end while (irq !== 1'b1 && cyc < 2000);
        chk(cyc < 2000, 32'h1);
    endtask
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        apb(1'b1, `TTW_OFF_DATA, 32'h7);
        apb(1'b1, `TTW_OFF_PWR, 32'h1);
        rchk(`TTW_OFF_DATA, 32'h0);
        apb(1'b1, `TTW_OFF_PRESC, 32'h0);
        apb(1'b1, `TTW_OFF_NF, 32'h1);
        apb(1'b1, `TTW_OFF_MODE, 32'h2cc);
        apb(1'b1, `TTW_OFF_TRIG, 32'h1);
        rchk(`TTW_OFF_TRIG, 32'h0);
        rchk(`TTW_OFF_STAT, 32'h1);
        pulse(16'd20);
        wait_irq;
        apb(1'b0, `TTW_OFF_DATA, 32'h0);
        chk(rd >= 32'd18 && rd <= 32'd21, 32'h1);
        rchk(`TTW_OFF_COUNT, rd + 32'h1);
        rchk(`TTW_OFF_STAT, 32'h1);
        apb(1'b1, `TTW_OFF_MODE, 32'h0);
        rchk(`TTW_OFF_MODE, 32'h2cc);
        apb(1'b1, `TTW_OFF_TRIG, 32'h2);
        rchk(`TTW_OFF_STAT, 32'h0);
        apb(1'b1, `TTW_OFF_NF, 32'h0);
        apb(1'b1, `TTW_OFF_MODE, 32'h248);
        apb(1'b1, `TTW_OFF_DATA, 32'h5);
        apb(1'b1, `TTW_OFF_TRIG, 32'h1);
        pulse(16'd3);
        wait_irq;
        rchk(`TTW_OFF_COUNT, 32'h0);
        apb(1'b1, `TTW_OFF_OUT, 32'h2);
        apb(1'b1, `TTW_OFF_TRIG, 32'h1);
        wait_irq;
        chk(cyc >= 5 && cyc <= 8, 32'h1);
        chk(tout, 32'h1);
        apb(1'b1, `TTW_OFF_TRIG, 32'h4);
        rchk(`TTW_OFF_STAT, 32'h3);
        apb(1'b0, 8'h40, 32'h0);
        chk(er, 32'h1);
        apb(1'b1, `TTW_OFF_PWR, 32'h0);
        rchk(`TTW_OFF_MODE, 32'h0);
        complete_run;
    end
    initial begin
        #(50 * 5000);
        n_fail++;
        complete_run;
    end
endmodule
